//--- core/blink_divider.sv
// Millisecond tick and fault blink level derived from pclk.
// Assumes a single clock; the tick is a one-cycle enable, never a clock.
`timescale 1ns/1ps

module blink_divider
   import supervisor_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
   parameter int unsigned BLINK_HALF_MS = `BLINK_HALF_MS
)
(
   input wire logic pclk,
   input wire logic presetn,
   output logic tick,
   output logic blink
);

   div_s s;
   div_s next_s;

   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt >= 32'(TICK_CYCLES - 1))
      begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
         if (s.half >= 16'(BLINK_HALF_MS - 1))
         begin
            next_s.half = '0;
            next_s.blink = ~s.blink;
         end
         else
            next_s.half = s.half + 16'h0001;
      end
      else
         next_s.cnt = s.cnt + 32'h0000_0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick = s.tick;
   assign blink = s.blink;

endmodule

//--- core/status_fault_supervisor.sv
// Supply supervision, status indicators, fault indication and jam recovery
// of a four-zone conveyor controller, with an APB register slave.
// Assumes one clock, an asynchronous power-up reset, asynchronous supply
// pins, and jam levels from zone logic on the same clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Network-power indicator goes off while network supply is below working range.
// - When network supply returns the device rejoins the bus on its own.
// - While network power is off, sensors count as dead and all motors stop.
// - Motor-power indicator goes off while motor supply is below working range.
// - Fault lit steadily for illegal config, processor not started, or overload.
// - Config illegal when start bit is not below zone 1 on one channel.
// - Legal config needs start below zone 1, and zone 1 below accumulate, wherever the two share a channel.
// - Writing a valid configuration clears a fault caused only by the config.
// - Fault indicator blinks instead of steady while any zone is jammed.
// - A jammed zone reverses its roller for the configured unjam time.
module status_fault_supervisor
   import supervisor_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
   parameter int unsigned BLINK_HALF_MS = `BLINK_HALF_MS
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic net_supply_good,
   input wire logic motor_supply_good,
   input wire logic motor_overload,
   input wire logic [`ZONE_COUNT-1:0] zone_jam,
   output logic net_power_led,
   output logic motor_power_led,
   output logic fault_led,
   output logic net_active,
   output logic sensors_enable,
   output logic motor_stop,
   output logic [`ZONE_COUNT-1:0] zone_reverse,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions.

   // True when address a fails to precede address b on a shared channel.
   // Addresses on different channels never collide, so they are not ordered.
   function automatic logic out_of_order(input logic [11:0] a, input logic [11:0] b);
      logic same_mux;
      same_mux = a[`ADDR_MUX_MSB:`ADDR_MUX_LSB] == b[`ADDR_MUX_MSB:`ADDR_MUX_LSB];
      return same_mux && (a[`ADDR_BIT_MSB:0] >= b[`ADDR_BIT_MSB:0]);
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      logic hit;
      if (addr == `OFS_CTRL)
         hit = 1'b1;
      else if (addr == `OFS_CFG_START)
         hit = 1'b1;
      else if (addr == `OFS_CFG_ZONE1)
         hit = 1'b1;
      else if (addr == `OFS_CFG_ACCUM)
         hit = 1'b1;
      else if (addr == `OFS_UNJAM)
         hit = 1'b1;
      else if (addr == `OFS_STATUS)
         hit = 1'b1;
      else if (addr == `OFS_IRQ_STATUS)
         hit = 1'b1;
      else if (addr == `OFS_IRQ_MASK)
         hit = 1'b1;
      else
         hit = 1'b0;
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised pins and time base.

   logic [`SYNC_W-1:0] pins_sync;
   logic net_ok;
   logic motor_ok;
   logic overload;
   logic tick;
   logic blink;

   supply_sync u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({motor_overload, motor_supply_good, net_supply_good}),
      .sync_out(pins_sync)
   );

   assign net_ok = pins_sync[0];
   assign motor_ok = pins_sync[1];
   assign overload = pins_sync[2];

   blink_divider #(
      .TICK_CYCLES(TICK_CYCLES),
      .BLINK_HALF_MS(BLINK_HALF_MS)
   ) u_div
   (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .blink(blink)
   );

   ////////////////////////////////////////////////////////////////////////////
   // State.

   sup_s s;
   sup_s next_s;

   logic cfg_illegal;
   logic steady_fault;
   logic [`ZONE_COUNT-1:0] jam_eff;
   logic [`ZONE_COUNT-1:0] jam_rise;
   logic [`IRQ_W-1:0] events;
   logic [31:0] status_word;

   // Order is checked on the stored words, so a valid write clears it at once.
   assign cfg_illegal = out_of_order(s.cfg_start, s.cfg_zone1)
      || out_of_order(s.cfg_zone1, s.cfg_accum);
   assign steady_fault = cfg_illegal || !s.cpu_started || overload;

   // Sensors are not trusted without network power, so jams are ignored then.
   assign jam_eff = zone_jam & {`ZONE_COUNT{net_ok}};
   assign jam_rise = jam_eff & ~s.jam_prev;

   always_comb
   begin
      events = '0;
      events[`IRQ_NET_LOST] = s.net_prev && !net_ok;
      events[`IRQ_NET_BACK] = !s.net_prev && net_ok;
      events[`IRQ_MOTOR_LOST] = s.motor_prev && !motor_ok;
      events[`IRQ_FAULT] = !s.steady_prev && steady_fault;
      events[`IRQ_JAM] = |jam_rise;
   end

   always_comb
   begin
      status_word = '0;
      status_word[0] = net_ok;
      status_word[1] = motor_ok;
      status_word[2] = steady_fault;
      status_word[3] = cfg_illegal;
      status_word[4] = overload;
      status_word[8 +: `ZONE_COUNT] = jam_eff;
      status_word[12 +: `ZONE_COUNT] = s.zone_reverse;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb
   begin
      next_s = s;

      // APB: first access cycle prepares the answer, the second completes it.
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (psel && penable && !s.pready)
      begin
         next_s.pready = 1'b1;
         next_s.pslverr = !is_mapped(paddr);
         next_s.prdata = '0;
         if (!pwrite)
         begin
            if (paddr == `OFS_CTRL)
               next_s.prdata[0] = s.cpu_started;
            else if (paddr == `OFS_CFG_START)
               next_s.prdata[11:0] = s.cfg_start;
            else if (paddr == `OFS_CFG_ZONE1)
               next_s.prdata[11:0] = s.cfg_zone1;
            else if (paddr == `OFS_CFG_ACCUM)
               next_s.prdata[11:0] = s.cfg_accum;
            else if (paddr == `OFS_UNJAM)
               next_s.prdata[15:0] = s.unjam_ms;
            else if (paddr == `OFS_STATUS)
               next_s.prdata = status_word;
            else if (paddr == `OFS_IRQ_STATUS)
               next_s.prdata[`IRQ_W-1:0] = s.irq_status;
            else if (paddr == `OFS_IRQ_MASK)
               next_s.prdata[`IRQ_W-1:0] = s.irq_mask;
         end
      end

      // Sticky events; a read clears only the bits it returned, so set wins.
      next_s.irq_status = s.irq_status | events;
      if (psel && penable && s.pready)
      begin
         if (pwrite)
         begin
            if (paddr == `OFS_CTRL)
               next_s.cpu_started = pwdata[0];
            else if (paddr == `OFS_CFG_START)
               next_s.cfg_start = pwdata[11:0];
            else if (paddr == `OFS_CFG_ZONE1)
               next_s.cfg_zone1 = pwdata[11:0];
            else if (paddr == `OFS_CFG_ACCUM)
               next_s.cfg_accum = pwdata[11:0];
            else if (paddr == `OFS_UNJAM)
               next_s.unjam_ms = pwdata[15:0];
            else if (paddr == `OFS_IRQ_MASK)
               next_s.irq_mask = pwdata[`IRQ_W-1:0];
         end
         else if (paddr == `OFS_IRQ_STATUS)
            next_s.irq_status = (s.irq_status & ~s.prdata[`IRQ_W-1:0]) | events;
      end

      // Jam recovery per zone.
      next_s.jam_prev = jam_eff;
      for (int i = 0; i < `ZONE_COUNT; i++)
      begin
         case (s.zone[i])
            ZONE_RUN:
            begin
               if (jam_rise[i])
               begin
                  next_s.unjam_cnt[i] = s.unjam_ms;
                  next_s.zone[i] = (s.unjam_ms == 16'h0000) ? ZONE_HOLD : ZONE_REVERSE;
               end
            end
            ZONE_REVERSE:
            begin
               if (!jam_eff[i])
                  next_s.zone[i] = ZONE_RUN;
               else if (tick)
               begin
                  if (s.unjam_cnt[i] <= 16'h0001)
                     next_s.zone[i] = ZONE_HOLD;
                  else
                     next_s.unjam_cnt[i] = s.unjam_cnt[i] - 16'h0001;
               end
            end
            ZONE_HOLD:
            begin
               if (!jam_eff[i])
                  next_s.zone[i] = ZONE_RUN;
            end
            default:
               next_s.zone[i] = ZONE_RUN;
         endcase
         next_s.zone_reverse[i] = (next_s.zone[i] == ZONE_REVERSE) && net_ok;
      end

      // Indicators and motor supervision.
      next_s.net_prev = net_ok;
      next_s.motor_prev = motor_ok;
      next_s.steady_prev = steady_fault;
      next_s.net_led = net_ok;
      next_s.net_active = net_ok;
      next_s.sensors_enable = net_ok;
      next_s.motor_stop = !net_ok;
      next_s.motor_led = motor_ok;
      if (|jam_eff)
         next_s.fault_led = blink;
      else
         next_s.fault_led = steady_fault;
      // Use the mask being written too, so the level never lags a mask change.
      next_s.irq = |(next_s.irq_status & next_s.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.cfg_start <= `RST_CFG_START;
         s.cfg_zone1 <= `RST_CFG_ZONE1;
         s.cfg_accum <= `RST_CFG_ACCUM;
         s.unjam_ms <= `RST_UNJAM_MS;
         s.irq_mask <= `RST_IRQ_MASK;
         s.motor_stop <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign net_power_led = s.net_led;
   assign motor_power_led = s.motor_led;
   assign fault_led = s.fault_led;
   assign net_active = s.net_active;
   assign sensors_enable = s.sensors_enable;
   assign motor_stop = s.motor_stop;
   assign zone_reverse = s.zone_reverse;
   assign irq = s.irq;

endmodule

//--- core/supervisor_params.svh
// Offsets, field positions, reset values and timing counts of the supervisor.
// Included by the package; holds definitions only.
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

`define ZONE_COUNT 4
`define IRQ_W 5
`define SYNC_W 3

// Register byte offsets on the APB.
`define OFS_CTRL 8'h00
`define OFS_CFG_START 8'h04
`define OFS_CFG_ZONE1 8'h08
`define OFS_CFG_ACCUM 8'h0C
`define OFS_UNJAM 8'h10
`define OFS_STATUS 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1C

// Address register layout: channel in the upper field, bit address below.
`define ADDR_BIT_MSB 7
`define ADDR_MUX_LSB 8
`define ADDR_MUX_MSB 11

// Reset values: an illegal layout (start 0/240, zone 1 0/16, accumulate 0/53).
`define RST_CFG_START 12'h0F0
`define RST_CFG_ZONE1 12'h010
`define RST_CFG_ACCUM 12'h035
`define RST_UNJAM_MS 16'h0BB8
`define RST_IRQ_MASK 5'h00

// Interrupt status bit positions.
`define IRQ_NET_LOST 0
`define IRQ_NET_BACK 1
`define IRQ_MOTOR_LOST 2
`define IRQ_FAULT 3
`define IRQ_JAM 4

// Time base: one millisecond tick derived from the 4 ns clock.
`define CLK_PERIOD_PS 4000
`define TICK_PERIOD_PS 1000000000
`define TICK_CYCLES (`TICK_PERIOD_PS / `CLK_PERIOD_PS)
`define BLINK_HALF_MS 250

`endif

//--- core/supervisor_pkg.sv
// Types shared by the supervisor modules.
// Assumes the constants header sits in the include path.
`include "supervisor_params.svh"

package supervisor_pkg;

   typedef enum logic [1:0] {ZONE_RUN, ZONE_REVERSE, ZONE_HOLD} zone_e;

   typedef struct packed {
      logic [`SYNC_W-1:0] stage1;
      logic [`SYNC_W-1:0] stage2;
   } sync_s;

   typedef struct packed {
      logic [31:0] cnt;
      logic [15:0] half;
      logic tick;
      logic blink;
   } div_s;

   typedef struct packed {
      logic cpu_started;
      logic [11:0] cfg_start;
      logic [11:0] cfg_zone1;
      logic [11:0] cfg_accum;
      logic [15:0] unjam_ms;
      logic [`IRQ_W-1:0] irq_status;
      logic [`IRQ_W-1:0] irq_mask;
      logic [`ZONE_COUNT-1:0] jam_prev;
      zone_e [`ZONE_COUNT-1:0] zone;
      logic [`ZONE_COUNT-1:0][15:0] unjam_cnt;
      logic net_prev;
      logic motor_prev;
      logic steady_prev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic net_led;
      logic motor_led;
      logic fault_led;
      logic net_active;
      logic sensors_enable;
      logic motor_stop;
      logic [`ZONE_COUNT-1:0] zone_reverse;
      logic irq;
   } sup_s;

endpackage

//--- core/supply_sync.sv
// Two-flop synchroniser for the supply-good and overload pins.
// Assumes the pins are asynchronous levels; only the second stage is read.
`timescale 1ns/1ps

module supply_sync
   import supervisor_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`SYNC_W-1:0] async_in,
   output logic [`SYNC_W-1:0] sync_out
);

   sync_s s;
   sync_s next_s;

   always_comb
   begin
      next_s = s;
      next_s.stage1 = async_in;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

   assign sync_out = s.stage2;

endmodule

//--- verif/sup_checker_properties.sv
// Port-level checks of the supervisor.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps

module sup_checker
   import supervisor_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
   parameter int unsigned BLINK_HALF_MS = `BLINK_HALF_MS
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic net_supply_good,
   input wire logic motor_supply_good,
   input wire logic motor_overload,
   input wire logic [`ZONE_COUNT-1:0] zone_jam,
   input wire logic net_power_led,
   input wire logic motor_power_led,
   input wire logic fault_led,
   input wire logic net_active,
   input wire logic sensors_enable,
   input wire logic motor_stop,
   input wire logic [`ZONE_COUNT-1:0] zone_reverse
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////
   a_net_led_off: assert property ($fell(net_supply_good) |-> ##3 !net_power_led)
      else $error("network led still on after supply loss");
   a_net_rejoin: assert property ($rose(net_supply_good) |-> ##3 (net_power_led && net_active))
      else $error("no rejoin after supply return");
   a_motors_held: assert property (!net_power_led |-> (motor_stop && !sensors_enable && zone_reverse == 0))
      else $error("motors or sensors live without network power");
   a_motor_led_off: assert property ($fell(motor_supply_good) |-> ##3 !motor_power_led)
      else $error("motor led still on after supply loss");
   a_overload_fault: assert property ((motor_overload && zone_jam == 0)[*4] |-> fault_led)
      else $error("overload without fault light");
   a_jam_reverse: assert property (($rose(zone_jam[0]) && net_power_led) |=> zone_reverse[0])
      else $error("jam did not start reverse");
   a_reverse_ends: assert property ($fell(zone_jam[0]) |=> !zone_reverse[0])
      else $error("reverse outlived the jam");
   a_apb_wait: assert property ((psel && penable && !pready) |=> pready)
      else $error("bus answer not after one wait state");
endmodule

bind status_fault_supervisor sup_checker #(.TICK_CYCLES(TICK_CYCLES), .BLINK_HALF_MS(BLINK_HALF_MS)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .net_supply_good(net_supply_good), .motor_supply_good(motor_supply_good),
   .motor_overload(motor_overload), .zone_jam(zone_jam), .net_power_led(net_power_led),
   .motor_power_led(motor_power_led), .fault_led(fault_led), .net_active(net_active),
   .sensors_enable(sensors_enable), .motor_stop(motor_stop), .zone_reverse(zone_reverse));

//--- verif/supply_partner.sv
// Model of the network power module and the motor supply as seen at the pins.
// Assumes the bench commands the levels; pins move off the clock edge.
`timescale 1ns/1ps

module supply_partner
(
   input wire logic cmd_net,
   input wire logic cmd_motor,
   input wire logic cmd_ovl,
   output wire logic net_supply_good,
   output wire logic motor_supply_good,
   output wire logic motor_overload
);
   // A fixed skew from the clock edge keeps every change away from the synchroniser's sampling edge.
   // The power module is modelled without its network clock, so no clock ever runs above the limit.
   assign #1.3 net_supply_good = cmd_net;
   assign #1.3 motor_supply_good = cmd_motor;
   assign #1.3 motor_overload = cmd_ovl;
endmodule

//--- verif/tb_top.sv
// Self-checking bench of the supervisor: APB master, supply partner, jam stimulus.
// Assumes short tick and blink counts so the whole run stays brief.
`timescale 1ns/1ps

module tb_top
   import supervisor_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [`ZONE_COUNT-1:0] zone_jam = 4'h0;
   logic cmd_net = 1'b1;
   logic cmd_motor = 1'b1;
   logic cmd_ovl = 1'b0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, nsg, msg, ovl, net_power_led, motor_power_led, fault_led;
   wire logic net_active, sensors_enable, motor_stop, irq;
   wire logic [`ZONE_COUNT-1:0] zone_reverse;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   int i, k, hi, lo;
   logic [31:0] rd;
   logic err, bad;
   logic [11:0] s, z, a;

   always #2 pclk = ~pclk;

   supply_partner u_sup (.cmd_net(cmd_net), .cmd_motor(cmd_motor), .cmd_ovl(cmd_ovl),
      .net_supply_good(nsg), .motor_supply_good(msg), .motor_overload(ovl));

   status_fault_supervisor #(.TICK_CYCLES(4), .BLINK_HALF_MS(2)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .net_supply_good(nsg), .motor_supply_good(msg),
      .motor_overload(ovl), .zone_jam(zone_jam), .net_power_led(net_power_led),
      .motor_power_led(motor_power_led), .fault_led(fault_led), .net_active(net_active),
      .sensors_enable(sensors_enable), .motor_stop(motor_stop), .zone_reverse(zone_reverse), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // The request stands until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 50, 1, "bus answer");
   endtask

   function automatic logic cfg_bad(input logic [11:0] st, input logic [11:0] zo, input logic [11:0] ac);
      return (st[11:8] == zo[11:8] && st[7:0] >= zo[7:0]) || (zo[11:8] == ac[11:8] && zo[7:0] >= ac[7:0]);
   endfunction

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         $display("ERROR %0t run did not finish", $time);
         print_verdict();
      end
   end

   initial
   begin
      void'($urandom(95));
      cyc(16);
      presetn <= 1'b1;
      cyc(6);
      chk(fault_led, 1, "fault before processor start");
      apb(1'b1, `OFS_CTRL, 32'h0000_0001);
      for (i = 0; i < 12; i++)
      begin
         s = {4'($urandom_range(1, 0)), 8'($urandom)};
         z = {4'($urandom_range(1, 0)), 8'($urandom)};
         a = {4'($urandom_range(1, 0)), 8'($urandom)};
         case (i)
            0: {s, z, a} = {12'h010, 12'h010, 12'h035};
            1: {s, z, a} = {12'h110, 12'h010, 12'h035};
            2: {s, z, a} = {12'h00F, 12'h035, 12'h035};
            11: {s, z, a} = {12'h0F0, 12'h0F0, 12'h135};
            default: ;
         endcase
         bad = cfg_bad(s, z, a);
         apb(1'b1, `OFS_CFG_START, {20'h0_0000, s});
         apb(1'b1, `OFS_CFG_ZONE1, {20'h0_0000, z});
         apb(1'b1, `OFS_CFG_ACCUM, {20'h0_0000, a});
         apb(1'b0, `OFS_STATUS, 32'h0000_0000);
         chk(rd[3], bad, "illegal flag");
         cyc(4);
         chk(fault_led, bad, "config fault");
      end
      apb(1'b1, `OFS_CFG_START, 32'h0000_00F0);
      apb(1'b1, `OFS_CFG_ZONE1, 32'h0000_0110);
      apb(1'b1, `OFS_CFG_ACCUM, 32'h0000_0135);
      cyc(4);
      chk(fault_led, 0, "fault cleared by good config");
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001, "unmapped read error");
      chk(rd, 32'h0000_0000, "unmapped read data");
      apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
      cmd_net <= 1'b0;
      cyc(5);
      chk({net_power_led, motor_stop, sensors_enable, irq}, 4'b0101, "network loss");
      zone_jam <= 4'h1;
      cyc(3);
      chk(zone_reverse, 0, "jam ignored without network");
      zone_jam <= 4'h0;
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
      chk(rd[0], 1, "loss event latched");
      cyc(2);
      chk(irq, 0, "irq cleared by read");
      cmd_net <= 1'b1;
      cyc(5);
      chk({net_power_led, net_active, sensors_enable, motor_stop}, 4'b1110, "rejoin");
      cmd_motor <= 1'b0;
      cyc(5);
      chk(motor_power_led, 0, "motor supply loss");
      cmd_motor <= 1'b1;
      cmd_ovl <= 1'b1;
      cyc(5);
      chk({motor_power_led, fault_led}, 2'b11, "overload fault");
      cmd_ovl <= 1'b0;
      cyc(5);
      chk(fault_led, 0, "overload gone");
      apb(1'b1, `OFS_UNJAM, 32'h0000_0002);
      k = $urandom_range(3, 0);
      zone_jam <= 4'b0001 | 4'(1 << k);
      cyc(2);
      chk(zone_reverse, 4'b0001 | 4'(1 << k), "reverse on jam");
      hi = 0;
      lo = 0;
      repeat (40)
      begin
         @(posedge pclk);
         if (fault_led === 1'b1)
            hi++;
         if (fault_led === 1'b0)
            lo++;
      end
      chk(hi > 0 && lo > 0, 1, "fault blinks during jam");
      chk(zone_reverse, 0, "reverse ends after unjam time");
      zone_jam <= 4'h0;
      cyc(4);
      chk(fault_led, 0, "blink ends with jam");
      print_verdict();
   end
endmodule
